// file: tpm_map.svh
// Purpose: offsets, field positions and timing counts of the T1 monitor pin interface
// Assumes: mclk at 10 MHz
// Notes:   definitions only
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH

// ----------------------------------------
// clock and link timing
// ----------------------------------------
`define TPM_MCLK_KHZ          10000
`define TPM_LINE_KHZ          1544
`define TPM_STREAM_KHZ        2048
`define TPM_STREAM_HALF_CYC   4'h8
`define TPM_LINE_HALF_CYC     4'h4

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define TPM_STREAM_LAST_SLOT  8'hFF
`define TPM_LINE_LAST_BIT     8'hC0

// ----------------------------------------
// channels of the second input stream
// ----------------------------------------
`define TPM_CH_BOM            5'h07
`define TPM_CH_CTRL           5'h0B
`define TPM_CH_LOOP           5'h0F

// ----------------------------------------
// channels inserted into the output stream
// ----------------------------------------
`define TPM_CH_FE_STAT        5'h03
`define TPM_CH_BPV_STAT       5'h04

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define TPM_CTRL_MARKER_EN    2
`define TPM_LOOP_STREAM_EN    0
`define TPM_CTRL_RESET        8'h00
`define TPM_LOOP_RESET        8'h00
`define TPM_BOM_RESET         8'hFF

`endif

// file: tpm_pkg.sv
// Purpose: shared types and helpers of the T1 monitor pin interface
// Assumes: nothing beyond tpm_map.svh
// Notes:   no constants here, see the map header
package tpm_pkg;

    typedef logic [7:0] tpm_byte_t;
    typedef logic [4:0] tpm_chan_t;

    // raw pins seen by the monitor end, in one vector for the synchroniser
    typedef struct packed {
        logic lclk;
        logic rail_a;
        logic rail_b;
        logic marker;
        logic sclk;
        logic frame_n;
        logic first;
        logic second;
    } tpm_pins_t;

    function automatic tpm_chan_t tpm_chan(input tpm_byte_t slot);
        return slot[7:3];
    endfunction : tpm_chan

    // saturating count, an error burst must not wrap to a small value
    function automatic tpm_byte_t tpm_sat_inc(input tpm_byte_t v);
        return (v == 8'hFF) ? v : tpm_byte_t'(v + 8'h01);
    endfunction : tpm_sat_inc

endpackage : tpm_pkg

// file: tpm_link_if.sv
// Purpose: pins between the monitor and the framer side
// Assumes: all signals are plain one-way wires
// Notes:   frame pulse and rails are active low
`timescale 1ns/100ps
interface tpm_link_if;
    // line side
    logic recovered_line_clock;
    logic receive_rail_a_n;
    logic receive_rail_b_n;
    logic frame_marker_in_n;
    logic frame_marker_out_n;
    // stream side
    logic stream_bit_clock;
    logic stream_frame_pulse_n;
    logic control_stream_in_first;
    logic control_stream_in_second;
    logic control_stream_out;

    modport dev_mp (
        input  recovered_line_clock,
        input  receive_rail_a_n,
        input  receive_rail_b_n,
        input  frame_marker_in_n,
        output frame_marker_out_n,
        input  stream_bit_clock,
        input  stream_frame_pulse_n,
        input  control_stream_in_first,
        input  control_stream_in_second,
        output control_stream_out
    );

    modport host_mp (
        output recovered_line_clock,
        output receive_rail_a_n,
        output receive_rail_b_n,
        output frame_marker_in_n,
        input  frame_marker_out_n,
        output stream_bit_clock,
        output stream_frame_pulse_n,
        output control_stream_in_first,
        output control_stream_in_second,
        input  control_stream_out
    );
endinterface : tpm_link_if

// file: tpm_framer_host.sv
// Purpose: framer side of the link, makes both link clocks and both input streams
// Assumes: mclk at 10 MHz, clocks made by dividers
// Notes:   link clocks are slower than nominal, mclk/16 and mclk/8
`timescale 1ns/100ps
`include "tpm_map.svh"
module tpm_framer_host (
    // system
    input  logic            mclk,
    input  logic            rstn,
    // link
    tpm_link_if.host_mp     link,
    // words for the second stream
    input  tpm_pkg::tpm_byte_t ctrl_word_in,
    input  tpm_pkg::tpm_byte_t bom_word_in,
    input  tpm_pkg::tpm_byte_t loop_word_in,
    // first stream fill and line payload
    input  tpm_pkg::tpm_byte_t first_fill,
    input  logic            line_data,
    input  logic            force_fbit_error,
    // received output stream
    output tpm_pkg::tpm_byte_t rx_byte,
    output tpm_pkg::tpm_chan_t rx_chan,
    output logic            rx_valid,
    output logic            marker_seen_n
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [3:0]         sdiv_reg, sdiv_next, ldiv_reg, ldiv_next;
    logic               sclk_reg, sclk_next, lclk_reg, lclk_next;
    tpm_pkg::tpm_byte_t slot_reg, slot_next, lbit_reg, lbit_next;
    logic               fp_reg, fp_next, cs0_reg, cs0_next, cs1_reg, cs1_next;
    logic               ra_reg, ra_next, rb_reg, rb_next, fmi_reg, fmi_next;
    logic               fpat_reg, fpat_next, ami_reg, ami_next;
    logic [1:0]         o_s1_reg, o_s2_reg;
    tpm_pkg::tpm_byte_t rsh_reg, rsh_next, rxb_reg, rxb_next;
    tpm_pkg::tpm_chan_t rxc_reg, rxc_next;
    logic               rxv_reg, rxv_next;

    tpm_pkg::tpm_byte_t ch_byte;
    logic               lb;
    tpm_pkg::tpm_byte_t sbyte;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb begin
        sdiv_next = sdiv_reg + 4'h1;
        sclk_next = sclk_reg;
        ldiv_next = ldiv_reg + 4'h1;
        lclk_next = lclk_reg;
        {slot_next, fp_next, cs0_next, cs1_next} = {slot_reg, fp_reg, cs0_reg, cs1_reg};
        {lbit_next, ra_next, rb_next, fmi_next} = {lbit_reg, ra_reg, rb_reg, fmi_reg};
        fpat_next = fpat_reg;
        ami_next  = ami_reg;
        rsh_next  = rsh_reg;
        rxb_next  = rxb_reg;
        rxc_next  = rxc_reg;
        rxv_next  = 1'b0;
        ch_byte   = 8'hFF;
        lb        = 1'b0;
        sbyte     = 8'h00;
        // stream clock: falling edge moves to the next slot
        if (sdiv_reg == `TPM_STREAM_HALF_CYC - 4'h1) begin
            sdiv_next = 4'h0;
            sclk_next = ~sclk_reg;
            if (sclk_reg) begin
                // output stream is valid by our falling edge
                sbyte    = {rsh_reg[6:0], o_s2_reg[0]};
                rsh_next = sbyte;
                if (slot_reg[2:0] == 3'h7) begin
                    rxb_next = sbyte;
                    rxc_next = tpm_pkg::tpm_chan(slot_reg);
                    rxv_next = 1'b1;
                end
                slot_next = slot_reg + 8'h01;
                unique case (tpm_pkg::tpm_chan(slot_next))
                    `TPM_CH_CTRL: ch_byte = ctrl_word_in;
                    `TPM_CH_BOM:  ch_byte = bom_word_in;
                    `TPM_CH_LOOP: ch_byte = loop_word_in;
                    default:      ch_byte = 8'hFF;
                endcase
                fp_next  = (slot_next != `TPM_STREAM_LAST_SLOT);
                cs0_next = first_fill[3'h7 - slot_next[2:0]];
                cs1_next = ch_byte[3'h7 - slot_next[2:0]];
            end
        end
        // line clock: falling edge presents the next bit
        if (ldiv_reg == `TPM_LINE_HALF_CYC - 4'h1) begin
            ldiv_next = 4'h0;
            lclk_next = ~lclk_reg;
            if (lclk_reg) begin
                lbit_next = (lbit_reg == `TPM_LINE_LAST_BIT) ? 8'h00 : lbit_reg + 8'h01;
                if (lbit_next == 8'h00) begin
                    fpat_next = ~fpat_reg;
                    lb        = fpat_reg ^ force_fbit_error;
                end else begin
                    lb        = line_data;
                end
                fmi_next = (lbit_next != 8'h00);
                // alternate mark inversion, marks are active low
                ra_next = ~(lb & ~ami_reg);
                rb_next = ~(lb & ami_reg);
                if (lb) begin
                    ami_next = ~ami_reg;
                end
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {sdiv_reg, ldiv_reg, sclk_reg, lclk_reg} <= {4'h0, 4'h0, 1'b0, 1'b0};
            slot_reg <= 8'hFE;
            lbit_reg <= `TPM_LINE_LAST_BIT;
            {fp_reg, cs0_reg, cs1_reg} <= 3'h7;
            {ra_reg, rb_reg, fmi_reg}  <= 3'h7;
            {fpat_reg, ami_reg}        <= 2'h0;
            {o_s1_reg, o_s2_reg}       <= 4'hF;
            {rsh_reg, rxb_reg, rxc_reg, rxv_reg} <= {8'h00, 8'h00, 5'h00, 1'b0};
        end else begin
            {sdiv_reg, ldiv_reg, sclk_reg, lclk_reg} <= {sdiv_next, ldiv_next, sclk_next, lclk_next};
            {slot_reg, lbit_reg} <= {slot_next, lbit_next};
            {fp_reg, cs0_reg, cs1_reg} <= {fp_next, cs0_next, cs1_next};
            {ra_reg, rb_reg, fmi_reg}  <= {ra_next, rb_next, fmi_next};
            {fpat_reg, ami_reg}        <= {fpat_next, ami_next};
            o_s1_reg <= {link.frame_marker_out_n, link.control_stream_out};
            o_s2_reg <= o_s1_reg;
            {rsh_reg, rxb_reg, rxc_reg, rxv_reg} <= {rsh_next, rxb_next, rxc_next, rxv_next};
        end
    end

    assign link.stream_bit_clock         = sclk_reg;
    assign link.recovered_line_clock     = lclk_reg;
    assign link.stream_frame_pulse_n     = fp_reg;
    assign link.control_stream_in_first  = cs0_reg;
    assign link.control_stream_in_second = cs1_reg;
    assign link.receive_rail_a_n         = ra_reg;
    assign link.receive_rail_b_n         = rb_reg;
    assign link.frame_marker_in_n        = fmi_reg;
    assign rx_byte       = rxb_reg;
    assign rx_chan       = rxc_reg;
    assign rx_valid      = rxv_reg;
    assign marker_seen_n = o_s2_reg[1];
endmodule : tpm_framer_host

// file: tpm_monitor_dev.sv
// Purpose: monitor end of the T1 pin interface
// Assumes: link pins asynchronous to mclk, link clocks well below mclk/4
// Notes:   both link clocks are sampled, never used as clocks
//
// Operation
// - sample both rails on recovered line clock
// - rail low level marks a pulse
// - frame marker low locates framing bit, check errors
// - marker out follows input when enabled, else high
// - pass first stream and replace own channels, or pass second stream whole in loopback
// - channel 11 of second stream is control
// - channel 7 of second stream is message
// - channel 15 of second stream controls loopback
// - frame pulse marks every stream frame boundary
// - stream bit clock shifts streams in and out
// - low reset suspends all functions
`timescale 1ns/100ps
`include "tpm_map.svh"
module tpm_monitor_dev (
    // system
    input  logic               mclk,
    input  logic               rstn,
    // link
    tpm_link_if.dev_mp         link,
    // decoded control channels
    output tpm_pkg::tpm_byte_t ctrl_word,
    output tpm_pkg::tpm_byte_t bom_word,
    output tpm_pkg::tpm_byte_t loop_word,
    // line results
    output tpm_pkg::tpm_byte_t fe_count,
    output tpm_pkg::tpm_byte_t bpv_count
);
    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    tpm_pkg::tpm_pins_t pin_s1_reg, pin_s1_next, pin_s2_reg;

    always_comb begin
        pin_s1_next = {link.recovered_line_clock, link.receive_rail_a_n, link.receive_rail_b_n,
                       link.frame_marker_in_n, link.stream_bit_clock, link.stream_frame_pulse_n,
                       link.control_stream_in_first, link.control_stream_in_second};
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_reg <= 8'hFF;
            pin_s2_reg <= 8'hFF;
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ----------------------------------------
    // line side: framing and rail checks
    // ----------------------------------------
    logic               lclk_d_reg, lclk_d_next;
    logic               fprev_reg, fprev_next, fvalid_reg, fvalid_next;
    logic               mlast_reg, mlast_next, mvalid_reg, mvalid_next;
    tpm_pkg::tpm_byte_t fe_cnt_reg, fe_cnt_next, bpv_cnt_reg, bpv_cnt_next;
    logic               line_rise, mark_a, mark_b, fbit;

    always_comb begin
        lclk_d_next  = pin_s2_reg.lclk;
        fprev_next   = fprev_reg;
        fvalid_next  = fvalid_reg;
        mlast_next   = mlast_reg;
        mvalid_next  = mvalid_reg;
        fe_cnt_next  = fe_cnt_reg;
        bpv_cnt_next = bpv_cnt_reg;
        line_rise    = pin_s2_reg.lclk & ~lclk_d_reg;
        mark_a       = ~pin_s2_reg.rail_a;
        mark_b       = ~pin_s2_reg.rail_b;
        fbit         = mark_a | mark_b;
        if (line_rise) begin
            // framing bits alternate, a repeat is a framing error
            if (!pin_s2_reg.marker) begin
                if (fvalid_reg && (fbit == fprev_reg)) begin
                    fe_cnt_next = tpm_pkg::tpm_sat_inc(fe_cnt_reg);
                end
                fprev_next  = fbit;
                fvalid_next = 1'b1;
            end
            // two marks in a row on one rail break the alternation
            if (mark_a ^ mark_b) begin
                if (mvalid_reg && (mlast_reg == mark_b)) begin
                    bpv_cnt_next = tpm_pkg::tpm_sat_inc(bpv_cnt_reg);
                end
                mlast_next  = mark_b;
                mvalid_next = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // same level as the synchroniser reset, so no false edge after release
            lclk_d_reg  <= 1'b1;
            fprev_reg   <= 1'b0;
            fvalid_reg  <= 1'b0;
            mlast_reg   <= 1'b0;
            mvalid_reg  <= 1'b0;
            fe_cnt_reg  <= 8'h00;
            bpv_cnt_reg <= 8'h00;
        end else begin
            lclk_d_reg  <= lclk_d_next;
            fprev_reg   <= fprev_next;
            fvalid_reg  <= fvalid_next;
            mlast_reg   <= mlast_next;
            mvalid_reg  <= mvalid_next;
            fe_cnt_reg  <= fe_cnt_next;
            bpv_cnt_reg <= bpv_cnt_next;
        end
    end

    // ----------------------------------------
    // stream side: channel capture and insertion
    // ----------------------------------------
    logic               sclk_d_reg, sclk_d_next;
    tpm_pkg::tpm_byte_t slot_reg, slot_next, shift_reg, shift_next;
    tpm_pkg::tpm_byte_t ctrl_reg, ctrl_next, bom_reg, bom_next, loop_reg, loop_next;
    tpm_pkg::tpm_byte_t snap_fe_reg, snap_fe_next, snap_bpv_reg, snap_bpv_next;
    logic               out_reg, out_next, fmo_reg, fmo_next;
    logic               stream_rise;
    tpm_pkg::tpm_byte_t byte_in;
    tpm_pkg::tpm_chan_t chan;
    logic [2:0]         bsel;

    always_comb begin
        sclk_d_next   = pin_s2_reg.sclk;
        slot_next     = slot_reg;
        shift_next    = shift_reg;
        ctrl_next     = ctrl_reg;
        bom_next      = bom_reg;
        loop_next     = loop_reg;
        snap_fe_next  = snap_fe_reg;
        snap_bpv_next = snap_bpv_reg;
        out_next      = out_reg;
        stream_rise   = pin_s2_reg.sclk & ~sclk_d_reg;
        byte_in       = {shift_reg[6:0], pin_s2_reg.second};
        chan          = tpm_pkg::tpm_chan(slot_reg);
        bsel          = 3'h7 - slot_reg[2:0];
        if (stream_rise) begin
            // the pulse sits in the last slot, channel 0 follows it
            slot_next  = pin_s2_reg.frame_n ? slot_reg + 8'h01 : 8'h00;
            shift_next = byte_in;
            if (slot_reg[2:0] == 3'h7) begin
                unique case (chan)
                    `TPM_CH_CTRL: ctrl_next = byte_in;
                    `TPM_CH_BOM:  bom_next  = byte_in;
                    `TPM_CH_LOOP: loop_next = byte_in;
                    default:      ;
                endcase
            end
            // snapshot once per frame so a channel never mixes two counts
            if (!pin_s2_reg.frame_n) begin
                snap_fe_next  = fe_cnt_reg;
                snap_bpv_next = bpv_cnt_reg;
            end
            if (loop_reg[`TPM_LOOP_STREAM_EN]) begin
                out_next = pin_s2_reg.second;
            end else if (chan == `TPM_CH_FE_STAT) begin
                out_next = snap_fe_reg[bsel];
            end else if (chan == `TPM_CH_BPV_STAT) begin
                out_next = snap_bpv_reg[bsel];
            end else begin
                out_next = pin_s2_reg.first;
            end
        end
        // marker repeat lags the input by the synchroniser depth plus the output register, three mclk
        fmo_next = ctrl_reg[`TPM_CTRL_MARKER_EN] ? pin_s2_reg.marker : 1'b1;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_reg   <= 1'b1;
            slot_reg     <= 8'h00;
            shift_reg    <= 8'h00;
            ctrl_reg     <= `TPM_CTRL_RESET;
            bom_reg      <= `TPM_BOM_RESET;
            loop_reg     <= `TPM_LOOP_RESET;
            snap_fe_reg  <= 8'h00;
            snap_bpv_reg <= 8'h00;
            out_reg      <= 1'b1;
            fmo_reg      <= 1'b1;
        end else begin
            sclk_d_reg   <= sclk_d_next;
            slot_reg     <= slot_next;
            shift_reg    <= shift_next;
            ctrl_reg     <= ctrl_next;
            bom_reg      <= bom_next;
            loop_reg     <= loop_next;
            snap_fe_reg  <= snap_fe_next;
            snap_bpv_reg <= snap_bpv_next;
            out_reg      <= out_next;
            fmo_reg      <= fmo_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.control_stream_out = out_reg;
    assign link.frame_marker_out_n = fmo_reg;
    assign ctrl_word = ctrl_reg;
    assign bom_word  = bom_reg;
    assign loop_word = loop_reg;
    assign fe_count  = fe_cnt_reg;
    assign bpv_count = bpv_cnt_reg;
endmodule : tpm_monitor_dev

// file: tpm_link_chk.sv
// Purpose: checks on the pins between the two ends
// Assumes: one mclk domain, link clocks made from mclk
// Notes:   control words are not visible here
`timescale 1ns/100ps
module tpm_link_chk (
    // system
    input logic mclk,
    input logic rstn,
    // line side
    input logic recovered_line_clock,
    input logic receive_rail_a_n,
    input logic receive_rail_b_n,
    input logic frame_marker_in_n,
    input logic frame_marker_out_n,
    // stream side
    input logic stream_bit_clock,
    input logic stream_frame_pulse_n,
    input logic control_stream_in_first,
    input logic control_stream_in_second,
    input logic control_stream_out
);
    // ----------------------------------------
    // frame length counter
    // ----------------------------------------
    logic        pd_reg, pd_next;
    logic        seen_reg, seen_next;
    logic [12:0] gap_reg, gap_next;
    logic        pfell;

    always_comb begin
        pfell     = pd_reg & ~stream_frame_pulse_n;
        pd_next   = stream_frame_pulse_n;
        seen_next = seen_reg | pfell;
        gap_next  = pfell ? 13'h0000 : gap_reg + 13'h0001;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pd_reg   <= 1'b1;
            seen_reg <= 1'b0;
            gap_reg  <= 13'h0000;
        end else begin
            pd_reg   <= pd_next;
            seen_reg <= seen_next;
            gap_reg  <= gap_next;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence lhi_s; recovered_line_clock [*4]; endsequence
    sequence llo_s; !recovered_line_clock [*4]; endsequence
    sequence shi_s; stream_bit_clock [*8]; endsequence
    sequence slo_s; !stream_bit_clock [*8]; endsequence

    reset_idle_a: assert property (disable iff (1'b0)
        !rstn |-> control_stream_out && frame_marker_out_n) else $error("outputs not idle in reset");
    line_period_a: assert property ($rose(recovered_line_clock) |-> lhi_s ##1 llo_s ##1 recovered_line_clock)
        else $error("line clock period wrong");
    slot_period_a: assert property ($rose(stream_bit_clock) |-> shi_s ##1 slo_s)
        else $error("stream clock period wrong");
    rail_edge_a: assert property ($changed({receive_rail_a_n, receive_rail_b_n, frame_marker_in_n})
        |-> $fell(recovered_line_clock)) else $error("line pins move off line clock fall");
    rail_ami_a: assert property (receive_rail_a_n || receive_rail_b_n)
        else $error("both rails low");
    marker_len_a: assert property ($fell(frame_marker_in_n) |-> !frame_marker_in_n [*8] ##1 frame_marker_in_n)
        else $error("marker not one line bit");
    marker_out_a: assert property (!frame_marker_out_n |-> !$past(frame_marker_in_n, 3))
        else $error("marker out low without marker in");
    pulse_len_a: assert property ($fell(stream_frame_pulse_n) |-> ##15 !stream_frame_pulse_n ##1 stream_frame_pulse_n)
        else $error("frame pulse not one slot");
    frame_gap_a: assert property (pfell && seen_reg |-> gap_reg == 13'h0FFF)
        else $error("frame not 256 slots");
    stream_edge_a: assert property ($changed({stream_frame_pulse_n, control_stream_in_first,
        control_stream_in_second}) |-> $fell(stream_bit_clock)) else $error("stream pins move off clock fall");
    out_edge_a: assert property ($changed(control_stream_out)
        |-> $past(stream_bit_clock, 3) && !$past(stream_bit_clock, 5)) else $error("output moved off slot");
endmodule : tpm_link_chk

// file: test_t1_monitor_pin_interface.sv
// Purpose: end to end test of monitor and framer ends
// Assumes: mclk 10 MHz, one stream frame is 4096 mclk
// Notes:   results read through the framer's received bytes and the monitor's outputs
`timescale 1ns/100ps
module test_t1_monitor_pin_interface;
    logic               mclk = 1'b0;
    logic               rstn = 1'b1;
    tpm_pkg::tpm_byte_t ctrl_word_in = 8'h00;
    tpm_pkg::tpm_byte_t bom_word_in = 8'hFF;
    tpm_pkg::tpm_byte_t loop_word_in = 8'h00;
    tpm_pkg::tpm_byte_t first_fill = 8'h00;
    logic               line_data = 1'b1;
    logic               force_fbit_error = 1'b0;
    tpm_pkg::tpm_byte_t rx_byte, ctrl_word, bom_word, loop_word, fe_count, bpv_count, b;
    tpm_pkg::tpm_chan_t rx_chan;
    logic               rx_valid, marker_seen_n, low;
    int                 err_count = 0;
    int                 num_checks = 0;
    int                 cycles = 0;

    always #50 mclk = ~mclk;

    tpm_link_if tpm_link_if_inst ();
    tpm_framer_host tpm_framer_host_inst (.mclk(mclk), .rstn(rstn), .link(tpm_link_if_inst),
        .ctrl_word_in(ctrl_word_in), .bom_word_in(bom_word_in), .loop_word_in(loop_word_in),
        .first_fill(first_fill), .line_data(line_data), .force_fbit_error(force_fbit_error),
        .rx_byte(rx_byte), .rx_chan(rx_chan), .rx_valid(rx_valid), .marker_seen_n(marker_seen_n));
    tpm_monitor_dev tpm_monitor_dev_inst (.mclk(mclk), .rstn(rstn), .link(tpm_link_if_inst),
        .ctrl_word(ctrl_word), .bom_word(bom_word), .loop_word(loop_word),
        .fe_count(fe_count), .bpv_count(bpv_count));
    tpm_link_chk tpm_link_chk_inst (.mclk(mclk), .rstn(rstn),
        .recovered_line_clock(tpm_link_if_inst.recovered_line_clock),
        .receive_rail_a_n(tpm_link_if_inst.receive_rail_a_n),
        .receive_rail_b_n(tpm_link_if_inst.receive_rail_b_n),
        .frame_marker_in_n(tpm_link_if_inst.frame_marker_in_n),
        .frame_marker_out_n(tpm_link_if_inst.frame_marker_out_n),
        .stream_bit_clock(tpm_link_if_inst.stream_bit_clock),
        .stream_frame_pulse_n(tpm_link_if_inst.stream_frame_pulse_n),
        .control_stream_in_first(tpm_link_if_inst.control_stream_in_first),
        .control_stream_in_second(tpm_link_if_inst.control_stream_in_second),
        .control_stream_out(tpm_link_if_inst.control_stream_out));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string name, input tpm_pkg::tpm_byte_t seen, input tpm_pkg::tpm_byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic set_words(input tpm_pkg::tpm_byte_t c, bw, l, f);
        @(posedge mclk);
        ctrl_word_in <= c;
        bom_word_in <= bw;
        loop_word_in <= l;
        first_fill <= f;
    endtask : set_words

    task automatic frames(input int n);
        repeat (n * 4096) @(posedge mclk);
    endtask : frames

    // one received output channel, bounded by a little over a frame
    task automatic get_chan(input tpm_pkg::tpm_chan_t ch, output tpm_pkg::tpm_byte_t v);
        int n;
        v = 8'hXX;
        for (n = 0; n < 4300; n++) begin
            @(negedge mclk);
            if (rx_valid === 1'b1 && rx_chan === ch) begin
                v = rx_byte;
                break;
            end
        end
    endtask : get_chan

    // longer than one line frame, so one marker must show
    task automatic marker_low(output logic lo);
        lo = 1'b0;
        repeat (1600) begin
            @(negedge mclk);
            if (marker_seen_n === 1'b0) lo = 1'b1;
        end
    endtask : marker_low

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 95000) begin
            err_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        // a real fall at time 0, so every register is reset before the first edge
        rstn <= 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        check("ctrl_rst", ctrl_word, 8'h00);
        check("bom_rst", bom_word, 8'hFF);
        check("fe_rst", fe_count, 8'h00);
        set_words(8'h04, 8'h5A, 8'h00, 8'hA5);
        frames(3);
        check("ctrl", ctrl_word, 8'h04);
        check("bom", bom_word, 8'h5A);
        check("loop", loop_word, 8'h00);
        get_chan(5'h00, b);
        check("ch0", b, 8'hA5);
        get_chan(5'h1F, b);
        check("ch31", b, 8'hA5);
        get_chan(`TPM_CH_FE_STAT, b);
        check("ch_fe", b, 8'h00);
        get_chan(`TPM_CH_BPV_STAT, b);
        check("ch_bpv", b, 8'h00);
        marker_low(low);
        check("marker_on", {7'h00, low}, 8'h01);
        set_words(8'h00, 8'h5A, 8'h00, 8'hA5);
        frames(2);
        marker_low(low);
        check("marker_off", {7'h00, low}, 8'h00);
        // exactly one framing bit inverted breaks alternation twice
        @(posedge mclk);
        force_fbit_error <= 1'b1;
        repeat (1544) @(posedge mclk);
        force_fbit_error <= 1'b0;
        frames(2);
        check("fe", fe_count, 8'h02);
        check("bpv", bpv_count, 8'h00);
        get_chan(`TPM_CH_FE_STAT, b);
        check("ch_fe2", b, 8'h02);
        set_words(8'h00, 8'h5A, 8'h01, 8'hA5);
        frames(2);
        get_chan(5'h00, b);
        check("lb_ch0", b, 8'hFF);
        get_chan(`TPM_CH_CTRL, b);
        check("lb_ctrl", b, 8'h00);
        get_chan(`TPM_CH_LOOP, b);
        check("lb_loop", b, 8'h01);
        @(posedge mclk);
        rstn <= 1'b0;
        @(negedge mclk);
        check("cso_rst", {7'h00, tpm_link_if_inst.control_stream_out}, 8'h01);
        check("bom_rst2", bom_word, 8'hFF);
        check("fe_rst2", fe_count, 8'h00);
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        frames(2);
        check("bom_again", bom_word, 8'h5A);
        close_out();
    end
endmodule : test_t1_monitor_pin_interface
